// *** core/pmt_pkg.sv ***
// constants shared by the period match timer and its scaler
// assumes a single 125 MHz system clock that also stands for the oscillator
package pmt_pkg;

	// =========================================================
	// register bus
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 8;
	localparam logic [7:0]  OFF_COUNT    = 8'h00;
	localparam logic [7:0]  OFF_PERIOD   = 8'h01;
	localparam logic [7:0]  OFF_CONTROL  = 8'h02;
	localparam logic [7:0]  OFF_STATUS   = 8'h03;
	localparam logic [7:0]  OFF_MASK     = 8'h04;

	// =========================================================
	// control field layout
	localparam int          PRE_LSB      = 0;
	localparam int          PRE_W        = 2;
	localparam int          POST_LSB     = 2;
	localparam int          POST_W       = 4;
	localparam int          CTRL_W       = PRE_W + POST_W;
	localparam int          IRQ_BIT      = 0;

	// =========================================================
	// reset values
	localparam logic [7:0]  COUNT_RST    = 8'h00;
	localparam logic [7:0]  PERIOD_RST   = 8'hff;
	localparam logic [5:0]  CONTROL_RST  = 6'h00;

	// =========================================================
	// clock division
	localparam int          INSTR_DIV    = 4;
	localparam logic [1:0]  INSTR_LAST   = 2'(INSTR_DIV - 1);
	localparam logic [1:0]  PRE_SEL_DIV1 = 2'h0;
	localparam logic [1:0]  PRE_SEL_DIV4 = 2'h1;
	localparam logic [3:0]  PRE_LAST4    = 4'h3;
	localparam logic [3:0]  PRE_LAST16   = 4'hf;
	localparam logic [3:0]  PRE_RST      = 4'h0;
	localparam logic [3:0]  POST_RST     = 4'h0;

endpackage : pmt_pkg

// *** core/pmt_scale_if.sv ***
// link between the timer core and its clock scaler
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface pmt_scale_if;
	import pmt_pkg::*;
	logic             run;   // timer allowed to advance
	logic             clr;   // clear prescale counter
	logic [PRE_W-1:0] sel;   // prescale select
	logic             tick;  // one-cycle timer clock enable

	modport timer  (output run, output clr, output sel, input tick);
	modport scaler (input run, input clr, input sel, output tick);
endinterface : pmt_scale_if

// *** core/pmt_scaler.sv ***
// instruction clock divider and prescale counter of the period timer
// assumes run and clr come from logic on the same clock
`timescale 1ns/1ps
module pmt_scaler
	import pmt_pkg::*;
(
	input  wire logic  CLK_SYS,  // system clock
	input  wire logic  RESETN,   // async reset, low
	pmt_scale_if.scaler sc       // timer side
);

	// =========================================================
	// instruction clock
	logic [1:0] div_cnt;
	logic [3:0] pre_cnt;
	wire        instr_tick = sc.run && (div_cnt == INSTR_LAST);

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN)
			div_cnt <= 2'h0;
		else if (sc.run)
			div_cnt <= div_cnt + 2'h1;
	end

	// =========================================================
	// prescaler
	wire pre_done = (sc.sel == PRE_SEL_DIV1) ? 1'b1 :
	                (sc.sel == PRE_SEL_DIV4) ? ((pre_cnt & PRE_LAST4) == PRE_LAST4) :
	                (pre_cnt == PRE_LAST16);

	assign sc.tick = instr_tick && pre_done;

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN)
			pre_cnt <= PRE_RST;
		else if (sc.clr)
			pre_cnt <= PRE_RST;
		else if (instr_tick)
			pre_cnt <= pre_cnt + 4'h1;
	end

	// =========================================================
	// checks
	a_div1_direct: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(instr_tick && sc.sel == PRE_SEL_DIV1) |-> sc.tick)
		else $error("divide by one missed a tick");
	a_pre_clear: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		sc.clr |=> pre_cnt == PRE_RST)
		else $error("prescale counter not cleared");
	a_instr_rate: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(instr_tick && sc.run) ##1 sc.run [*3] |-> !instr_tick && $past(!instr_tick))
		else $error("instruction tick faster than a quarter");

endmodule : pmt_scaler

// *** core/pmt_timer.sv ***
// period match timer: 8-bit count, period compare, pre and post scaling
// assumes the register port and DEV_RESET, SLEEP come from the same clock
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module pmt_timer
	import pmt_pkg::*;
(
	input  wire logic              CLK_SYS,    // system clock, 125 MHz
	input  wire logic              RESETN,     // async reset, low
	input  wire logic              DEV_RESET,  // sync device reset pulse, high
	input  wire logic              SLEEP,      // processor asleep, high
	input  wire logic [ADDR_W-1:0] ADDR,       // register address
	input  wire logic [DATA_W-1:0] WDATA,      // write data
	input  wire logic              WR,         // write strobe
	input  wire logic              RD,         // read strobe
	output      logic [DATA_W-1:0] RDATA,      // read data, cycle after RD
	output      logic              MATCH_OUT,  // unscaled match pulse
	output      logic              IRQ         // interrupt request, high
);

	// =========================================================
	// address decode
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction : hit

	wire wr_count  = WR && hit(ADDR, OFF_COUNT);
	wire wr_period = WR && hit(ADDR, OFF_PERIOD);
	wire wr_ctrl   = WR && hit(ADDR, OFF_CONTROL);
	wire wr_mask   = WR && hit(ADDR, OFF_MASK);
	wire rd_status = RD && hit(ADDR, OFF_STATUS);

	// =========================================================
	// state
	logic [7:0]        timer_count;
	logic [7:0]        period_value;
	logic [CTRL_W-1:0] timer_control;
	logic [3:0]        post_cnt;
	logic              match_irq_flag;
	logic              match_irq_enable;

	wire [PRE_W-1:0]  prescale_select  = timer_control[PRE_LSB +: PRE_W];
	wire [POST_W-1:0] postscale_select = timer_control[POST_LSB +: POST_W];

	// =========================================================
	// scaler
	pmt_scale_if sc_if ();

	assign sc_if.run = !SLEEP;
	assign sc_if.clr = wr_count || wr_ctrl || DEV_RESET;
	assign sc_if.sel = prescale_select;

	pmt_scaler u_scaler (
		.CLK_SYS (CLK_SYS),
		.RESETN  (RESETN),
		.sc      (sc_if.scaler)
	);

	wire tick      = sc_if.tick;
	wire is_match  = (timer_count == period_value);
	wire match_ev  = tick && is_match && !wr_count;
	wire post_term = match_ev && (post_cnt == postscale_select);

	// =========================================================
	// count and period
	// a count write beats a tick landing in the same cycle
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN)
			timer_count <= COUNT_RST;
		else if (DEV_RESET)
			timer_count <= COUNT_RST;
		else if (wr_count)
			timer_count <= WDATA;
		else if (match_ev)
			timer_count <= COUNT_RST;
		else if (tick)
			timer_count <= timer_count + 8'h01;
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN)
			period_value <= PERIOD_RST;
		else if (DEV_RESET)
			period_value <= PERIOD_RST;
		else if (wr_period)
			period_value <= WDATA;
	end

	// control write never touches the count
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN)
			timer_control <= CONTROL_RST;
		else if (DEV_RESET)
			timer_control <= CONTROL_RST;
		else if (wr_ctrl)
			timer_control <= WDATA[CTRL_W-1:0];
	end

	// =========================================================
	// match output and postscaler
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN)
			MATCH_OUT <= 1'b0;
		else
			MATCH_OUT <= match_ev && !DEV_RESET;
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN)
			post_cnt <= POST_RST;
		else if (sc_if.clr)
			post_cnt <= POST_RST;
		else if (post_term)
			post_cnt <= POST_RST;
		else if (match_ev)
			post_cnt <= post_cnt + 4'h1;
	end

	// =========================================================
	// interrupt
	// set wins over the clear of a status read in the same cycle
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN)
			match_irq_flag <= 1'b0;
		else if (DEV_RESET)
			match_irq_flag <= 1'b0;
		else if (post_term)
			match_irq_flag <= 1'b1;
		else if (rd_status)
			match_irq_flag <= 1'b0;
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN)
			match_irq_enable <= 1'b0;
		else if (DEV_RESET)
			match_irq_enable <= 1'b0;
		else if (wr_mask)
			match_irq_enable <= WDATA[IRQ_BIT];
	end

	assign IRQ = match_irq_flag && match_irq_enable;

	// =========================================================
	// read port
	logic [DATA_W-1:0] next_rdata;

	always_comb begin
		next_rdata = '0;
		unique case (1'b1)
			hit(ADDR, OFF_COUNT):   next_rdata = timer_count;
			hit(ADDR, OFF_PERIOD):  next_rdata = period_value;
			hit(ADDR, OFF_CONTROL): next_rdata[CTRL_W-1:0] = timer_control;
			hit(ADDR, OFF_STATUS):  next_rdata[IRQ_BIT] = match_irq_flag;
			hit(ADDR, OFF_MASK):    next_rdata[IRQ_BIT] = match_irq_enable;
			default:                next_rdata = '0;
		endcase
	end

	// unmapped reads return zero; data only in the cycle after RD
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN)
			RDATA <= '0;
		else if (RD)
			RDATA <= next_rdata;
		else
			RDATA <= '0;
	end

	// =========================================================
	// checks
	a_match_clears: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(tick && is_match && !WR && !DEV_RESET) |=> MATCH_OUT && timer_count == COUNT_RST)
		else $error("match did not clear the count");
	a_count_step: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(tick && !is_match && !WR && !DEV_RESET) |=> timer_count == $past(timer_count) + 8'h01)
		else $error("count did not advance on tick");
	a_sleep_freeze: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(SLEEP && !WR && !DEV_RESET) |=> $stable(timer_count) && $stable(period_value))
		else $error("timer moved during sleep");
	a_dev_reset: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		DEV_RESET |=> timer_count == COUNT_RST && period_value == PERIOD_RST && post_cnt == POST_RST)
		else $error("device reset values wrong");
	a_ctrl_keeps: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(wr_ctrl && !tick && !DEV_RESET) |=> $stable(timer_count) && post_cnt == POST_RST)
		else $error("control write disturbed count or left postscaler");
	a_irq_gate: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		!match_irq_enable |-> !IRQ)
		else $error("interrupt raised while disabled");
	a_post_flag: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(match_ev && post_cnt == postscale_select && !DEV_RESET) |=> match_irq_flag && post_cnt == POST_RST)
		else $error("postscaler terminal missed the flag");
	a_post_count: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(match_ev && post_cnt != postscale_select && !sc_if.clr) |=> post_cnt == $past(post_cnt) + 4'h1 && !$rose(match_irq_flag))
		else $error("postscaler step wrong");
	a_flag_sticky: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(match_irq_flag && !rd_status && !DEV_RESET) |=> match_irq_flag)
		else $error("match flag dropped without a read");
	a_read_timing: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(RD && hit(ADDR, OFF_PERIOD) && !DEV_RESET) |=> RDATA == $past(period_value))
		else $error("period readback wrong");

endmodule : pmt_timer

// *** bench/pmt_pwm_model.sv ***
// far-side model: pwm time base and spi shift clock fed by the match pulse
// assumes the match pulse is one system clock long
`timescale 1ns/1ps
module pmt_pwm_model (
	input  wire logic CLK_SYS,    // system clock
	input  wire logic RESETN,     // async reset, low
	input  wire logic MATCH_OUT,  // unscaled match pulse
	output      int   periods,    // pwm periods seen
	output      logic spi_clk     // shift clock, one edge per match
);
	// =========================================================
	// consumer
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			periods <= 0;
			spi_clk <= 1'b0;
		end else if (MATCH_OUT) begin
			periods <= periods + 1;
			spi_clk <= ~spi_clk;
		end
	end
endmodule : pmt_pwm_model

// *** bench/tb.sv ***
// self-checking bench for the period match timer
// assumes one 125 MHz clock and the register map of pmt_pkg
`timescale 1ns/1ps
module tb;
	import pmt_pkg::*;
	logic              clk_sys;
	logic              resetn;
	logic              dev_reset;
	logic              sleep;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr;
	logic              rd;
	logic [DATA_W-1:0] rdata;
	logic              match_out;
	logic              irq;
	logic              spi_clk;
	logic [31:0]       seed;
	logic [7:0]        got;
	logic [7:0]        per;
	logic [3:0]        m;
	int                periods;
	int                fails = 0;
	int                compares = 0;
	int                cyc = 0;
	int                seen = 0;
	int                t0, n, k;

	// =========================================================
	// clock, design and far side
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) cyc <= cyc + 1;
	always @(posedge clk_sys) if (match_out === 1'b1) seen <= seen + 1;

	pmt_timer dut_u (.CLK_SYS(clk_sys), .RESETN(resetn), .DEV_RESET(dev_reset), .SLEEP(sleep),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .MATCH_OUT(match_out), .IRQ(irq));
	pmt_pwm_model far_u (.CLK_SYS(clk_sys), .RESETN(resetn), .MATCH_OUT(match_out), .periods(periods),
		.spi_clk(spi_clk));

	// =========================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic stop_test();
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %0h expected %0h", $time, g, e);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk_sys);
		wr    <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_sys);
		rd   <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	// steps past any pulse already showing, so spacing is measured edge to edge
	task automatic wait_match();
		k = 0;
		do begin
			@(posedge clk_sys);
			#1 k++;
		end while (match_out !== 1'b1 && k < 4000);
		if (k >= 4000) begin
			fails++;
			stop_test();
		end
	endtask : wait_match

	// =========================================================
	// scenarios
	initial begin
		resetn = 1'b0;
		dev_reset = 1'b0;
		sleep = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		seed = 32'd71005;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd_reg(8'(i), got);
			chk(got, (i == OFF_PERIOD) ? PERIOD_RST : 8'h00);
		end
		repeat (100) @(posedge clk_sys);
		rd_reg(OFF_COUNT, got);
		chk(got, COUNT_RST);
		chk(seen, 0);
		sleep <= 1'b0;
		// count and period read back; control write keeps count
		seed = lfsr(seed);
		wr_reg(OFF_PERIOD, seed[7:0]);
		rd_reg(OFF_PERIOD, got);
		chk(got, seed[7:0]);
		wr_reg(OFF_CONTROL, 8'h02);
		wr_reg(OFF_COUNT, seed[15:8]);
		wr_reg(OFF_CONTROL, 8'h02);
		rd_reg(OFF_COUNT, got);
		chk(got, seed[15:8]);
		// match spacing for every prescale code
		for (int s = 0; s < 4; s++) begin
			seed = lfsr(seed);
			per = {5'h0, seed[2:0]};
			wr_reg(OFF_PERIOD, per);
			wr_reg(OFF_CONTROL, 8'(s));
			wr_reg(OFF_COUNT, 8'h00);
			wait_match();
			t0 = cyc;
			wait_match();
			chk(cyc - t0, (per + 1) * INSTR_DIV * (s == 0 ? 1 : s == 1 ? 4 : 16));
		end
		// postscale ratios, flag and mask; last ratio 1:16 leaves time for the mask check
		wr_reg(OFF_MASK, 8'h01);
		wr_reg(OFF_PERIOD, 8'h01);
		for (int j = 0; j < 4; j++) begin
			seed = lfsr(seed);
			m = (j == 3) ? 4'hf : (j == 0) ? 4'h0 : seed[3:0];
			wait_match();
			wr_reg(OFF_CONTROL, {2'b00, m, 2'b00});
			rd_reg(OFF_STATUS, got);
			n = 0;
			for (k = 0; k < 1000 && irq !== 1'b1; k++) begin
				@(posedge clk_sys);
				#1 if (match_out === 1'b1) n++;
			end
			if (k >= 1000) begin
				fails++;
				stop_test();
			end
			@(posedge clk_sys);
			#1 if (match_out === 1'b1) n++;
			chk(n, m + 1);
		end
		wr_reg(OFF_MASK, 8'h00);
		// let the mask write settle before looking at the level output
		#1 chk(irq, 1'b0);
		rd_reg(OFF_STATUS, got);
		chk(got, 8'h01);
		rd_reg(OFF_STATUS, got);
		chk(got, 8'h00);
		// device reset in mid-run
		@(posedge clk_sys);
		dev_reset <= 1'b1;
		sleep     <= 1'b1;
		@(posedge clk_sys);
		dev_reset <= 1'b0;
		rd_reg(OFF_COUNT, got);
		chk(got, COUNT_RST);
		rd_reg(OFF_PERIOD, got);
		chk(got, PERIOD_RST);
		rd_reg(OFF_CONTROL, got);
		chk(got, 8'h00);
		chk(periods, seen);
		chk(spi_clk, seen[0]);
		stop_test();
	end
endmodule : tb
